// *** design/tfl_pkg.sv ***
`default_nettype none
package tfl_pkg;
  // Register offsets, plain register port
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] TEST_CTRL_ADDR = 8'h21;
  localparam logic [ADDR_W-1:0] TEST_STAT_ADDR = 8'h22;
  localparam logic [7:0] TEST_CTRL_RESET = 8'h00;
  // Field positions in the status register
  localparam int STAT_LOG_BIT = 0;
  localparam int STAT_AUDIO_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_OVR_BIT = 3;
  // Logging word layout on the processor data bus
  localparam int DSP_DATA_W = 24;
  localparam int LOG_WORD_MSB = 23;
  localparam int LOG_WORD_LSB = 8;
  localparam int NIBBLE_W = 4;
  localparam logic [1:0] LAST_NIBBLE = 2'h3;
  localparam int DSP_ADDR_W = 14;
  localparam logic [DSP_ADDR_W-1:0] LOG_DM_ADDR = 14'h0000;

  typedef struct packed {
    logic [3:0] spare;
    logic flash_wait_sel;
    logic general_output_ten_value;
    logic display_unused;
    logic logging_enable_flag;
  } tfl_ctrl_t;

  // One pad: output value and active-low output enable
  typedef struct packed {
    logic o;
    logic oe_n;
  } tfl_pad_t;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_AUDIO, MODE_LOG} tfl_mode_t;
  typedef enum logic {SER_IDLE, SER_SEND} tfl_ser_t;
endpackage
`default_nettype wire

// *** design/tfl_test_port.sv ***
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module tfl_test_port (
  input wire logic core_clk,
  input wire logic srst,
  // Register port
  input wire logic [tfl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Mode inputs
  input wire logic test_port_enable_pin,
  input wire logic emulation_mode,
  // Processor data-memory writes
  input wire logic dsp_wr,
  input wire logic [tfl_pkg::DSP_ADDR_W-1:0] dsp_addr,
  input wire logic [tfl_pkg::DSP_DATA_W-1:0] dsp_wdata,
  // Internal sources in normal operation
  input wire logic tap_tdo,
  input wire logic mem_clk_int,
  input wire logic mem_en_int,
  input wire logic vs_out_int,
  input wire logic vs_out_en_int,
  input wire logic flash_pwd_int,
  input wire logic addr20_int,
  input wire logic display_wait,
  // Audio test sources
  input wire logic audio_test_reset,
  input wire logic audio_test_out_bit1,
  input wire logic audio_test_receive,
  // Pad inputs
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic tdo_in,
  input wire logic vs_clk_in,
  input wire logic vs_fs_in,
  input wire logic vs_din_in,
  input wire logic flash_pwd_in,
  // Pad drives
  output tfl_pkg::tfl_pad_t tck_pad,
  output tfl_pkg::tfl_pad_t tms_pad,
  output tfl_pkg::tfl_pad_t tdi_pad,
  output tfl_pkg::tfl_pad_t tdo_pad,
  output tfl_pkg::tfl_pad_t serial_memory_clock,
  output tfl_pkg::tfl_pad_t serial_memory_enable,
  output tfl_pkg::tfl_pad_t voiceband_serial_out,
  output tfl_pkg::tfl_pad_t flash_power_down,
  output tfl_pkg::tfl_pad_t address_bit_twenty,
  // Toward internal logic
  output logic tap_tck,
  output logic tap_tms,
  output logic tap_tdi,
  output logic audio_test_in_bit0,
  output logic audio_test_clock,
  output logic audio_test_frame,
  output logic audio_test_transmit
);
  import tfl_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  wire [NSYNC-1:0] pins_raw = {test_port_enable_pin, tck_in, tms_in,
    tdi_in, tdo_in, vs_clk_in, vs_fs_in, vs_din_in, flash_pwd_in};
  always_ff @(posedge core_clk) begin
    sync1_reg <= pins_raw;
    sync2_reg <= sync1_reg;
  end
  wire port_en_s = sync2_reg[8];
  wire tck_s = sync2_reg[7];
  wire tms_s = sync2_reg[6];
  wire tdi_s = sync2_reg[5];
  wire tdo_s = sync2_reg[4];
  wire vs_clk_s = sync2_reg[3];
  wire vs_fs_s = sync2_reg[2];
  wire vs_din_s = sync2_reg[1];
  wire flash_s = sync2_reg[0];

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  tfl_ctrl_t ctrl_reg;
  logic ovr_reg;
  logic ovr_set;
  logic [7:0] reg_rdata_next;
  tfl_mode_t mode;
  tfl_ser_t ser_reg;

  wire ctrl_hit = reg_addr == TEST_CTRL_ADDR;
  wire stat_hit = reg_addr == TEST_STAT_ADDR;
  wire ovr_clr = reg_wr && stat_hit && reg_wdata[STAT_OVR_BIT];
  wire [7:0] stat_word = 8'(({7'h00, ovr_reg} << STAT_OVR_BIT)
    | ({7'h00, ser_reg == SER_SEND} << STAT_BUSY_BIT)
    | ({7'h00, mode == MODE_AUDIO} << STAT_AUDIO_BIT)
    | ({7'h00, mode == MODE_LOG} << STAT_LOG_BIT));

  always_comb begin
    if (!reg_rd) begin
      reg_rdata_next = 8'h00;
    end else if (ctrl_hit) begin
      reg_rdata_next = ctrl_reg;
    end else if (stat_hit) begin
      reg_rdata_next = stat_word;
    end else begin
      reg_rdata_next = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_reg <= TEST_CTRL_RESET;
      ovr_reg <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_wr && ctrl_hit) begin
        ctrl_reg <= {4'h0, reg_wdata[3:0]};
      end
      // Overrun set wins over a clear in the same cycle
      ovr_reg <= ovr_set | (ovr_reg & ~ovr_clr);
      reg_rdata <= reg_rdata_next;
    end
  end

  // ------------------------------------------------------------
  // Mode selection
  // ------------------------------------------------------------
  // two feature modes
  // logging needs port off and flag
  assign mode = port_en_s ? MODE_NORMAL
    : (ctrl_reg.logging_enable_flag ? MODE_LOG : MODE_AUDIO);
  wire log_mode = mode == MODE_LOG;
  wire audio_mode = mode == MODE_AUDIO;

  // ------------------------------------------------------------
  // Logging serialiser
  // ------------------------------------------------------------
  // Clock is core clock halved; a word takes eight core cycles, so
  // back-to-back writes at the five-cycle limit rely on one pending slot.
  logic lclk_reg;
  logic [15:0] shift_reg;
  logic [15:0] pend_reg;
  logic pend_v_reg;
  logic [1:0] cnt_reg;
  logic frame_reg;
  wire log_wr = log_mode && dsp_wr && dsp_addr == LOG_DM_ADDR;
  wire [15:0] log_word = dsp_wdata[LOG_WORD_MSB:LOG_WORD_LSB];
  wire rise = !lclk_reg;
  wire word_end = ser_reg == SER_SEND && cnt_reg == LAST_NIBBLE;
  wire take_pend = rise && pend_v_reg && (ser_reg == SER_IDLE || word_end);
  assign ovr_set = log_wr && pend_v_reg && !take_pend;

  always_ff @(posedge core_clk) begin
    if (srst || !log_mode) begin
      lclk_reg <= 1'b0;
      ser_reg <= SER_IDLE;
      shift_reg <= 16'h0000;
      pend_reg <= 16'h0000;
      pend_v_reg <= 1'b0;
      cnt_reg <= 2'h0;
      frame_reg <= 1'b0;
    end else begin
      lclk_reg <= ~lclk_reg;
      if (log_wr && (!pend_v_reg || take_pend)) begin
        pend_reg <= log_word;
        pend_v_reg <= 1'b1;
      end else if (take_pend) begin
        pend_v_reg <= 1'b0;
      end
      if (rise) begin
        case (ser_reg)
          SER_IDLE: begin
            frame_reg <= 1'b0;
            if (pend_v_reg) begin
              ser_reg <= SER_SEND;
              shift_reg <= pend_reg;
              cnt_reg <= 2'h0;
              frame_reg <= 1'b1;
            end
          end
          SER_SEND: begin
            if (word_end) begin
              if (pend_v_reg) begin
                shift_reg <= pend_reg;
                cnt_reg <= 2'h0;
              end else begin
                ser_reg <= SER_IDLE;
                frame_reg <= 1'b0;
              end
            end else begin
              shift_reg <= {shift_reg[11:0], 4'h0};
              cnt_reg <= cnt_reg + 2'h1;
            end
          end
          default: ser_reg <= SER_IDLE;
        endcase
      end
    end
  end
  wire [NIBBLE_W-1:0] nib = shift_reg[15:12];

  // ------------------------------------------------------------
  // Pad multiplexing
  // ------------------------------------------------------------
  // logging data on test pins
  // audio reassignment of TMS, TDI, TDO
  wire tfl_pad_t tck_n = log_mode ? {nib[0], 1'b0} : {1'b0, 1'b1};
  wire tfl_pad_t tms_n = log_mode ? {nib[1], 1'b0}
    : (audio_mode ? {audio_test_reset, 1'b0} : {1'b0, 1'b1});
  wire tfl_pad_t tdo_n = log_mode ? {nib[2], 1'b0}
    : (audio_mode ? {1'b0, 1'b1} : {tap_tdo, 1'b0});
  wire tfl_pad_t tdi_n = log_mode ? {nib[3], 1'b0}
    : (audio_mode ? {audio_test_out_bit1, 1'b0} : {1'b0, 1'b1});
  wire tfl_pad_t mclk_n = '{log_mode ? lclk_reg : mem_clk_int, 1'b0};
  wire tfl_pad_t men_n = '{log_mode ? frame_reg : mem_en_int, 1'b0};
  wire tfl_pad_t vso_n = audio_mode ? {audio_test_receive, 1'b0}
    : {vs_out_int, ~vs_out_en_int};
  wire tfl_pad_t fpd_n = !emulation_mode ? {flash_pwd_int, 1'b0}
    : (ctrl_reg.flash_wait_sel ? {1'b0, 1'b1} : {1'b1, 1'b0});
  wire wait_out = (ctrl_reg.flash_wait_sel & flash_s) | display_wait;
  wire a20_val = !emulation_mode ? addr20_int
    : (ctrl_reg.display_unused ? ctrl_reg.general_output_ten_value : wait_out);
  wire tfl_pad_t a20_n = '{a20_val, 1'b0};

  // Test port pins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tck_pad <= '{1'b0, 1'b1};
      tms_pad <= '{1'b0, 1'b1};
      tdi_pad <= '{1'b0, 1'b1};
      tdo_pad <= '{1'b0, 1'b1};
    end else begin
      tck_pad <= tck_n;
      tms_pad <= tms_n;
      tdi_pad <= tdi_n;
      tdo_pad <= tdo_n;
    end
  end

  // Memory, voiceband, flash and address pins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      serial_memory_clock <= '{1'b0, 1'b0};
      serial_memory_enable <= '{1'b0, 1'b0};
      voiceband_serial_out <= '{1'b0, 1'b1};
      flash_power_down <= '{1'b0, 1'b0};
      address_bit_twenty <= '{1'b0, 1'b0};
    end else begin
      serial_memory_clock <= mclk_n;
      serial_memory_enable <= men_n;
      voiceband_serial_out <= vso_n;
      flash_power_down <= fpd_n;
      address_bit_twenty <= a20_n;
    end
  end

  // ------------------------------------------------------------
  // Toward internal logic
  // ------------------------------------------------------------
  // Test pins held idle toward the port while it is off
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tap_tck <= 1'b0;
      tap_tms <= 1'b1;
      tap_tdi <= 1'b1;
      audio_test_in_bit0 <= 1'b0;
      audio_test_clock <= 1'b0;
      audio_test_frame <= 1'b0;
      audio_test_transmit <= 1'b0;
    end else begin
      tap_tck <= (mode == MODE_NORMAL) & tck_s;
      tap_tms <= (mode != MODE_NORMAL) | tms_s;
      tap_tdi <= (mode != MODE_NORMAL) | tdi_s;
      // TDO is audio input bit zero
      audio_test_in_bit0 <= audio_mode & tdo_s;
      audio_test_clock <= audio_mode & vs_clk_s;
      audio_test_frame <= audio_mode & vs_fs_s;
      audio_test_transmit <= audio_mode & vs_din_s;
    end
  end

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  // Shifter slices are written for one word of four nibbles
  if (LOG_WORD_MSB - LOG_WORD_LSB + 1 != $bits(shift_reg)) begin : g_word_w
    $error("logging word width does not match the shifter");
  end
  if ((LAST_NIBBLE + 1) * NIBBLE_W != $bits(shift_reg)) begin : g_nib_cnt
    $error("nibble count does not fill the shifter");
  end
  if (LOG_WORD_MSB >= DSP_DATA_W) begin : g_bus_w
    $error("logging word lies outside the processor data bus");
  end
  // Overlapping offsets would make one register shadow the other
  if (TEST_CTRL_ADDR == TEST_STAT_ADDR) begin : g_addr_map
    $error("control and status offsets collide");
  end
  if (STAT_OVR_BIT >= $bits(reg_rdata)) begin : g_stat_w
    $error("status field outside the read data");
  end
endmodule
`default_nettype wire

// *** verification/tfl_logger_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// External logger, listen only
// ----
// no return path
module tfl_logger_model (
  input wire logic core_clk,
  input wire logic log_clk,
  input wire logic log_frame,
  input wire logic [3:0] log_nib
);
  logic [15:0] words [8];
  logic [15:0] acc;
  logic clk_q;
  int word_count, idx;
  initial begin
    clk_q = 1'b0;
    acc = '0;
    word_count = 0;
    idx = 0;
  end
  always @(posedge core_clk) begin
    clk_q <= log_clk;
    if (clk_q && !log_clk && log_frame) begin
      acc = {acc[11:0], log_nib};
      idx = idx + 1;
      if (idx == 4) begin
        words[word_count % 8] = acc;
        word_count = word_count + 1;
        idx = 0;
      end
    end else if (!log_frame) begin
      idx = 0;
    end
  end
endmodule
`default_nettype wire

// *** verification/tfl_test_port_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checker
// ----
module tfl_test_port_monitor (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [tfl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic test_port_enable_pin,
  input wire logic emulation_mode,
  input wire logic display_wait,
  input wire logic audio_test_reset,
  input wire logic audio_test_receive,
  input wire tfl_pkg::tfl_pad_t tck_pad,
  input wire tfl_pkg::tfl_pad_t tms_pad,
  input wire tfl_pkg::tfl_pad_t tdi_pad,
  input wire tfl_pkg::tfl_pad_t tdo_pad,
  input wire tfl_pkg::tfl_pad_t serial_memory_clock,
  input wire tfl_pkg::tfl_pad_t serial_memory_enable,
  input wire tfl_pkg::tfl_pad_t voiceband_serial_out,
  input wire tfl_pkg::tfl_pad_t flash_power_down,
  input wire tfl_pkg::tfl_pad_t address_bit_twenty
);
  import tfl_pkg::*;
  logic [7:0] ctrl_q;
  wire log_on = !tck_pad.oe_n;
  wire audio_on = tck_pad.oe_n && !tms_pad.oe_n;
  wire [3:0] nib = {tdi_pad.o, tdo_pad.o, tms_pad.o, tck_pad.o};
  // Shadow of control, since the checker sees no register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_q <= 8'h00;
    end else if (reg_wr && reg_addr == TEST_CTRL_ADDR) begin
      ctrl_q <= reg_wdata;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  log_pads_a: assert property (log_on |-> !tms_pad.oe_n
    && !tdo_pad.oe_n && !tdi_pad.oe_n && !serial_memory_clock.oe_n
    && !serial_memory_enable.oe_n) else $error("logging pad not driven");
  flag_gate_a: assert property (!ctrl_q[0] [*4] |-> !log_on)
    else $error("logging without flag");
  pin_gate_a: assert property (test_port_enable_pin [*6] |-> !log_on)
    else $error("logging with port in use");
  clock_runs_a: assert property (log_on [*3] |->
    serial_memory_clock.o != $past(serial_memory_clock.o))
    else $error("logging clock stopped");
  frame_edge_a: assert property (log_on && $past(log_on)
    && $changed(serial_memory_enable.o) |-> serial_memory_clock.o)
    else $error("frame moved off clock rise");
  data_edge_a: assert property (log_on && $past(log_on)
    && serial_memory_enable.o && !$stable(nib) |-> serial_memory_clock.o)
    else $error("nibble moved off clock rise");
  frame_len_a: assert property (log_on &&
    $rose(serial_memory_enable.o) |-> serial_memory_enable.o [*8])
    else $error("frame shorter than four nibbles");
  audio_pins_a: assert property (audio_on |-> tdo_pad.oe_n
    && !tdi_pad.oe_n && tms_pad.o == $past(audio_test_reset))
    else $error("audio test pins wrong");
  audio_vso_a: assert property (audio_on |->
    !voiceband_serial_out.oe_n
    && voiceband_serial_out.o == $past(audio_test_receive))
    else $error("audio receive not routed");
  wait_out_a: assert property ($past(emulation_mode, 2)
    && !$past(ctrl_q[1]) && $past(display_wait) |-> address_bit_twenty.o)
    else $error("wait output missed");
  gpo_ten_a: assert property ($past(emulation_mode, 2)
    && $past(ctrl_q[1]) |-> address_bit_twenty.o == $past(ctrl_q[2]))
    else $error("output ten wrong");
  flash_high_a: assert property ($past(emulation_mode, 2)
    && !$past(ctrl_q[3]) |-> flash_power_down.o && !flash_power_down.oe_n)
    else $error("flash pin not forced high");
endmodule
bind tfl_test_port tfl_test_port_monitor u_mon (.core_clk, .srst,
  .reg_addr, .reg_wdata, .reg_wr, .test_port_enable_pin, .emulation_mode,
  .display_wait, .audio_test_reset, .audio_test_receive, .tck_pad, .tms_pad,
  .tdi_pad, .tdo_pad, .serial_memory_clock, .serial_memory_enable,
  .voiceband_serial_out, .flash_power_down, .address_bit_twenty);
`default_nettype wire

// *** verification/tfl_test_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tfl_test_port_tb;
  import tfl_pkg::*;
  logic core_clk, srst, reg_wr, reg_rd, dsp_wr, test_port_enable_pin;
  logic emulation_mode, tap_tdo, mem_clk_int, mem_en_int, vs_out_int;
  logic vs_out_en_int, flash_pwd_int, addr20_int, display_wait;
  logic audio_test_reset, audio_test_out_bit1, audio_test_receive;
  logic tck_in, tms_in, tdi_in, tdo_in, vs_clk_in, vs_fs_in, vs_din_in;
  logic flash_pwd_in, tap_tck, tap_tms, tap_tdi, audio_test_in_bit0;
  logic audio_test_clock, audio_test_frame, audio_test_transmit;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [DSP_ADDR_W-1:0] dsp_addr;
  logic [DSP_DATA_W-1:0] dsp_wdata;
  tfl_pad_t tck_pad, tms_pad, tdi_pad, tdo_pad, serial_memory_clock;
  tfl_pad_t serial_memory_enable, voiceband_serial_out, flash_power_down;
  tfl_pad_t address_bit_twenty;
  logic [15:0] words [3] = '{16'hA5C3, 16'h7E18, 16'h0FF0};
  // Control, wait, flash pin, wait out, flash oe_n
  logic [7:0] emu [6] = '{8'h0A, 8'h04, 8'h87, 8'h81, 8'h28, 8'h62};
  int errors, check_count, cycles, i;
  tfl_test_port u_dut (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .test_port_enable_pin, .emulation_mode, .dsp_wr,
    .dsp_addr, .dsp_wdata, .tap_tdo, .mem_clk_int, .mem_en_int, .vs_out_int,
    .vs_out_en_int, .flash_pwd_int, .addr20_int, .display_wait,
    .audio_test_reset, .audio_test_out_bit1, .audio_test_receive, .tck_in,
    .tms_in, .tdi_in, .tdo_in, .vs_clk_in, .vs_fs_in, .vs_din_in,
    .flash_pwd_in, .tck_pad, .tms_pad, .tdi_pad, .tdo_pad,
    .serial_memory_clock, .serial_memory_enable, .voiceband_serial_out,
    .flash_power_down, .address_bit_twenty, .tap_tck, .tap_tms, .tap_tdi,
    .audio_test_in_bit0, .audio_test_clock, .audio_test_frame,
    .audio_test_transmit);
  tfl_logger_model u_log (.core_clk, .log_clk(serial_memory_clock.o),
    .log_frame(serial_memory_enable.o),
    .log_nib({tdi_pad.o, tdo_pad.o, tms_pad.o, tck_pad.o}));
  // ----
  // Clocks and bus tasks
  // ----
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Off-grid phase, so the audio clock never lands on a core edge
  initial begin
    vs_clk_in = 1'b0;
    #7;
    forever #160 vs_clk_in = ~vs_clk_in;
  end
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp, string nm);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, {8'h00, exp}, {8'h00, reg_rdata});
  endtask
  task automatic dw(logic [13:0] a, logic [15:0] w);
    @(posedge core_clk);
    dsp_wr <= 1'b1;
    dsp_addr <= a;
    dsp_wdata <= {w, 8'h5A};
    @(posedge core_clk);
    dsp_wr <= 1'b0;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Whole run is some 250 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      conclude();
    end
  end
  // ----
  // Tests
  // ----
  initial begin
    srst = 1'b1;
    test_port_enable_pin = 1'b1;
    {reg_wr, reg_rd, dsp_wr, emulation_mode, tap_tdo, mem_clk_int,
      mem_en_int, vs_out_int, vs_out_en_int, flash_pwd_int, addr20_int,
      display_wait, audio_test_reset, audio_test_out_bit1,
      audio_test_receive, tck_in, tms_in, tdi_in, tdo_in, vs_fs_in,
      vs_din_in, flash_pwd_in, reg_addr, reg_wdata, dsp_addr,
      dsp_wdata} = '0;
    {errors, check_count, cycles} = '0;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    cyc(3);
    rd(TEST_CTRL_ADDR, 8'h00, "ctrl reset");
    chk("tap tms", 1'b0, tap_tms);
    chk("vs normal", 2'b01, voiceband_serial_out);
    rd(8'h5A, 8'h00, "unmapped read");
    wr(8'h5A, 8'hFF);
    wr(TEST_CTRL_ADDR, 8'hFF);
    rd(TEST_CTRL_ADDR, 8'h0F, "ctrl bits");
    cyc(6);
    rd(TEST_STAT_ADDR, 8'h00, "no mode");
    wr(TEST_CTRL_ADDR, 8'h00);
    $display("test registers done");
    @(posedge core_clk);
    test_port_enable_pin <= 1'b0;
    {tck_in, tms_in, tdi_in, addr20_int, flash_pwd_int} <= '1;
    {audio_test_reset, audio_test_out_bit1, audio_test_receive} <= '1;
    {tdo_in, vs_fs_in, vs_din_in} <= '1;
    cyc(8);
    rd(TEST_STAT_ADDR, 8'h02, "audio status");
    chk("tms pad", 2'b10, tms_pad);
    chk("tdi pad", 2'b10, tdi_pad);
    chk("tdo dir", 1'b1, tdo_pad.oe_n);
    chk("test in", 1'b1, audio_test_in_bit0);
    chk("vs out", 2'b10, voiceband_serial_out);
    chk("test frame", 1'b1, audio_test_frame);
    chk("test tx", 1'b1, audio_test_transmit);
    chk("tap tck", 1'b0, tap_tck);
    chk("a20 normal", 2'b10, address_bit_twenty);
    chk("flash normal", 2'b10, flash_power_down);
    @(posedge vs_clk_in);
    cyc(4);
    chk("test clock hi", 1'b1, audio_test_clock);
    @(negedge vs_clk_in);
    cyc(4);
    chk("test clock lo", 1'b0, audio_test_clock);
    $display("test audio done");
    wr(TEST_CTRL_ADDR, 8'h01);
    cyc(4);
    rd(TEST_STAT_ADDR, 8'h01, "log status");
    chk("mem clk dir", 1'b0, serial_memory_clock.oe_n);
    dw(14'h0000, words[0]);
    cyc(3);
    dw(14'h0000, words[1]);
    cyc(3);
    dw(14'h0100, 16'hFFFF);
    cyc(20);
    dw(14'h0000, words[2]);
    cyc(30);
    chk("word count", 16'd3, u_log.word_count[15:0]);
    for (i = 0; i < 3; i++) begin
      chk("word", words[i], u_log.words[i]);
    end
    // Writes two cycles apart: the third finds the slot full
    dw(14'h0000, words[0]);
    dw(14'h0000, words[1]);
    dw(14'h0000, words[2]);
    cyc(30);
    chk("burst count", 16'd5, u_log.word_count[15:0]);
    chk("burst word", words[0], u_log.words[3]);
    chk("burst next", words[1], u_log.words[4]);
    rd(TEST_STAT_ADDR, 8'h09, "overrun set");
    wr(TEST_STAT_ADDR, 8'h08);
    rd(TEST_STAT_ADDR, 8'h01, "overrun clear");
    wr(TEST_CTRL_ADDR, 8'h00);
    cyc(4);
    chk("tck back", 1'b1, tck_pad.oe_n);
    chk("reset back", 2'b10, tms_pad);
    dw(14'h0000, words[0]);
    cyc(20);
    chk("idle count", 16'd5, u_log.word_count[15:0]);
    $display("test logging done");
    @(posedge core_clk);
    emulation_mode <= 1'b1;
    for (i = 0; i < 6; i++) begin
      wr(TEST_CTRL_ADDR, {4'h0, emu[i][7:4]});
      @(posedge core_clk);
      display_wait <= emu[i][3];
      flash_pwd_in <= emu[i][2];
      cyc(5);
      chk("wait pin", emu[i][1], address_bit_twenty.o);
      chk("flash dir", emu[i][0], flash_power_down.oe_n);
    end
    $display("test emulation done");
    conclude();
  end
endmodule
`default_nettype wire
